// ===== shared/pmode_pkg.sv
package pmode_pkg;

   // Register offsets on the plain register port.
   localparam logic [5:0] BANK_OFS  = 6'h03;
   localparam logic [5:0] MODE_OFS  = 6'h05;
   localparam logic [5:0] MASK_OFS  = 6'h0f;
   localparam logic [5:0] FLAG_OFS  = 6'h10;
   localparam logic [5:0] STAT_OFS  = 6'h11;

   // Bank number under which the mode control register is visible.
   localparam logic [1:0] MODE_BANK = 2'h0;

   // Bank select field inside the bank register.
   localparam int BANK_LSB = 6;
   localparam int BANK_MSB = 7;

   // Field positions of the mode control register.
   localparam int WAKE_EDGE_BIT  = 0;
   localparam int SLEEP_SEL_BIT  = 1;
   localparam int MODE_ONE_BIT   = 2;
   localparam int PRESCALE_LSB   = 4;
   localparam int PRESCALE_MSB   = 6;

   // Field positions shared by the mask and flag registers.
   localparam int TICK_BIT     = 0;
   localparam int EXT_ONE_BIT  = 2;
   localparam int TIMEBASE_BIT = 3;
   localparam int TX_EMPTY_BIT = 4;
   localparam int RX_FULL_BIT  = 5;
   localparam int UART_ERR_BIT = 6;

   // Field positions of the status register.
   localparam int STAT_GIE_BIT = 4;

   // Reset values.
   localparam logic [1:0] BANK_RST     = 2'h0;
   localparam logic [2:0] PRESCALE_RST = 3'h0;
   localparam logic       SLEEP_SEL_RST = 1'b0;
   localparam logic       WAKE_EDGE_RST = 1'b0;
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic       GIE_RST      = 1'b0;

   // Default oscillator warm-up length in clock cycles.
   localparam int WARMUP_CYCLES_DEF = 1024;

   // Interrupt sources handled by the second mask register.
   typedef struct packed {
      logic uart_error_flag;
      logic rx_full_flag;
      logic tx_empty_flag;
      logic timebase_flag;
      logic ext_one_flag;
      logic tick_counter_flag;
   } irq_src_t;

   // Operating modes, one-hot.
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'b0001,
      MODE_IDLE   = 4'b0010,
      MODE_SLEEP  = 4'b0100,
      MODE_WARMUP = 4'b1000
   } op_mode_t;

   // Clock gate controls toward the clock tree.
   typedef struct packed {
      logic osc_en;
      logic cpu_clk_en;
      logic periph_clk_en;
   } clk_gate_t;

endpackage

// ===== rtl/power_mode_ctrl.sv
// How it works
// - Mask bit 6 gates UART error flag.
// - Mask bit 5 gates receive-full flag.
// - Mask bit 4 gates transmit-empty flag.
// - Mask bit 3 gates time-base flag.
// - Mask bit 2 gates external input one.
// - Mask bit 0 gates tick flag; 7,1 zero.
// - Interrupt needs mask bit and global enable.
// - Second mask register is byte read/write.
// - Halt with sleep select set enters sleep.
// - Halt with sleep select clear enters idle.
// - Normal mode clocks CPU and peripherals.
// - Idle stops CPU; enabled interrupt wakes.
// - Idle exit: service interrupt if enabled.
// - Reset pin low resets every mode.
// - Sleep stops oscillator, CPU, peripherals.
// - Only wake pin, reset pin or watchdog ends sleep; level/edge.
// - Wake pin then warm-up, then resume.
// - Edge wake: sleep even with pin low.
// - Masked-off sources still latch their flags.
// - Mode control at 0x05 of bank zero.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module power_mode_ctrl #(
   parameter int WARMUP_CYCLES = pmode_pkg::WARMUP_CYCLES_DEF
) (
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Register port.
   input  wire logic [5:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata_r,
   // CPU core operations, one-cycle pulses.
   input  wire logic                halt_instruction,
   input  wire logic                global_irq_on_op,
   input  wire logic                global_irq_off_op,
   input  wire logic                return_from_irq_op,
   input  wire logic                irq_taken,
   // Interrupt source events and watchdog timeout.
   input  wire pmode_pkg::irq_src_t irq_events,
   input  wire logic                wdt_timeout,
   // External wake pin, active low, asynchronous.
   input  wire logic                wake_n,
   // Toward CPU and clock tree.
   output logic                     irq_req_r,
   output logic                     resume_r,
   output pmode_pkg::clk_gate_t     clk_gate_r,
   output pmode_pkg::op_mode_t      mode_r
);

   // Maps a register byte onto the interrupt source fields.
   function automatic pmode_pkg::irq_src_t byte_to_src(input logic [7:0] b);
      pmode_pkg::irq_src_t s;
      s.uart_error_flag   = b[pmode_pkg::UART_ERR_BIT];
      s.rx_full_flag      = b[pmode_pkg::RX_FULL_BIT];
      s.tx_empty_flag     = b[pmode_pkg::TX_EMPTY_BIT];
      s.timebase_flag     = b[pmode_pkg::TIMEBASE_BIT];
      s.ext_one_flag      = b[pmode_pkg::EXT_ONE_BIT];
      s.tick_counter_flag = b[pmode_pkg::TICK_BIT];
      return s;
   endfunction

   // Places the interrupt source fields into a byte; unused bits are zero.
   function automatic logic [7:0] src_to_byte(input pmode_pkg::irq_src_t s);
      logic [7:0] b;
      b = 8'h00;
      b[pmode_pkg::UART_ERR_BIT] = s.uart_error_flag;
      b[pmode_pkg::RX_FULL_BIT]  = s.rx_full_flag;
      b[pmode_pkg::TX_EMPTY_BIT] = s.tx_empty_flag;
      b[pmode_pkg::TIMEBASE_BIT] = s.timebase_flag;
      b[pmode_pkg::EXT_ONE_BIT]  = s.ext_one_flag;
      b[pmode_pkg::TICK_BIT]     = s.tick_counter_flag;
      return b;
   endfunction

   localparam logic [15:0] WARMUP_LAST = 16'(WARMUP_CYCLES - 1);

   // Wake pin synchroniser and edge history.
   logic wake_s1_r;
   logic wake_s2_r;
   logic wake_s3_r;

   // Register and mode state.
   logic [1:0]           bank_r;
   logic [1:0]           bank_nxt;
   logic [2:0]           prescale_r;
   logic [2:0]           prescale_nxt;
   logic                 sleep_sel_r;
   logic                 sleep_sel_nxt;
   logic                 wake_edge_r;
   logic                 wake_edge_nxt;
   pmode_pkg::irq_src_t  mask_r;
   pmode_pkg::irq_src_t  mask_nxt;
   pmode_pkg::irq_src_t  flags_r;
   pmode_pkg::irq_src_t  flags_nxt;
   logic                 gie_r;
   logic                 gie_nxt;
   logic [15:0]          warm_cnt_r;
   logic [15:0]          warm_cnt_nxt;
   pmode_pkg::op_mode_t  mode_nxt;
   pmode_pkg::clk_gate_t clk_gate_nxt;
   logic                 irq_req_nxt;
   logic                 resume_nxt;
   logic [7:0]           rdata_nxt;

   // Decode helpers.
   logic                 mode_sel;
   logic                 pending;
   logic                 wake_hit;
   logic [7:0]           mode_byte;
   logic [7:0]           stat_byte;

   // Two flip-flops bring the wake pin into the clock domain, a third keeps history.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_s1_r <= 1'b1;
         wake_s2_r <= 1'b1;
         wake_s3_r <= 1'b1;
      end
      else
      begin
         wake_s1_r <= wake_n;
         wake_s2_r <= wake_s1_r;
         wake_s3_r <= wake_s2_r;
      end
   end

   // Mode control is visible only while bank zero is selected.
   assign mode_sel  = (reg_addr == pmode_pkg::MODE_OFS) && (bank_r == pmode_pkg::MODE_BANK);
   // Any latched flag whose mask bit is set.
   assign pending   = |(flags_r & mask_r);
   // Level wake sees a low pin, edge wake a falling edge.
   assign wake_hit  = wake_edge_r ? (wake_s3_r && !wake_s2_r) : !wake_s2_r;

   // Read views of the mode control and status registers.
   always_comb
   begin
      mode_byte = 8'h00;
      mode_byte[pmode_pkg::PRESCALE_MSB:pmode_pkg::PRESCALE_LSB] = prescale_r;
      mode_byte[pmode_pkg::MODE_ONE_BIT]  = 1'b1;
      mode_byte[pmode_pkg::SLEEP_SEL_BIT] = sleep_sel_r;
      mode_byte[pmode_pkg::WAKE_EDGE_BIT] = wake_edge_r;
      stat_byte = {4'h0, mode_r};
      stat_byte[pmode_pkg::STAT_GIE_BIT] = gie_r;
   end

   // Next values of registers, mode, clock gates and outputs.
   always_comb
   begin
      bank_nxt      = bank_r;
      prescale_nxt  = prescale_r;
      sleep_sel_nxt = sleep_sel_r;
      wake_edge_nxt = wake_edge_r;
      mask_nxt      = mask_r;
      flags_nxt     = flags_r;
      gie_nxt       = gie_r;
      warm_cnt_nxt  = warm_cnt_r;
      mode_nxt      = mode_r;
      resume_nxt    = 1'b0;
      rdata_nxt     = 8'h00;

      // Software writes.
      if (reg_wr)
      begin
         if (reg_addr == pmode_pkg::BANK_OFS)
            bank_nxt = reg_wdata[pmode_pkg::BANK_MSB:pmode_pkg::BANK_LSB];
         if (mode_sel)
         begin
            prescale_nxt  = reg_wdata[pmode_pkg::PRESCALE_MSB:pmode_pkg::PRESCALE_LSB];
            sleep_sel_nxt = reg_wdata[pmode_pkg::SLEEP_SEL_BIT];
            wake_edge_nxt = reg_wdata[pmode_pkg::WAKE_EDGE_BIT];
         end
         if (reg_addr == pmode_pkg::MASK_OFS)
            mask_nxt = byte_to_src(reg_wdata);
         if (reg_addr == pmode_pkg::FLAG_OFS)
            flags_nxt = byte_to_src(reg_wdata);
      end

      // Source events latch in every mode and win over a clearing write.
      flags_nxt = flags_nxt | irq_events;

      // Global enable; taking an interrupt masks further ones.
      if (global_irq_on_op || return_from_irq_op)
         gie_nxt = 1'b1;
      else if (global_irq_off_op || irq_taken)
         gie_nxt = 1'b0;

      // Mode sequencing.
      case (mode_r)
         pmode_pkg::MODE_NORMAL:
         begin
            if (halt_instruction)
               mode_nxt = sleep_sel_r ? pmode_pkg::MODE_SLEEP : pmode_pkg::MODE_IDLE;
         end
         pmode_pkg::MODE_IDLE:
         begin
            if (pending)
            begin
               mode_nxt   = pmode_pkg::MODE_NORMAL;
               resume_nxt = 1'b1;
            end
         end
         pmode_pkg::MODE_SLEEP:
         begin
            // Interrupt flags have no effect here; only the pin wakes.
            if (wake_hit)
            begin
               mode_nxt     = pmode_pkg::MODE_WARMUP;
               warm_cnt_nxt = 16'h0000;
            end
         end
         pmode_pkg::MODE_WARMUP:
         begin
            if (warm_cnt_r == WARMUP_LAST)
            begin
               mode_nxt   = pmode_pkg::MODE_NORMAL;
               resume_nxt = 1'b1;
            end
            else
               warm_cnt_nxt = warm_cnt_r + 16'h0001;
         end
         default:
            mode_nxt = pmode_pkg::MODE_NORMAL;
      endcase

      // Clock gates follow the next mode.
      clk_gate_nxt.osc_en        = (mode_nxt != pmode_pkg::MODE_SLEEP);
      clk_gate_nxt.cpu_clk_en    = (mode_nxt == pmode_pkg::MODE_NORMAL);
      clk_gate_nxt.periph_clk_en = (mode_nxt == pmode_pkg::MODE_NORMAL) ||
                                   (mode_nxt == pmode_pkg::MODE_IDLE);

      // The CPU sees a request only while running with global enable set.
      irq_req_nxt = gie_nxt && |(flags_nxt & mask_nxt) &&
                    (mode_nxt == pmode_pkg::MODE_NORMAL);

      // Read data stand for one cycle after the read strobe.
      if (reg_rd)
      begin
         if (reg_addr == pmode_pkg::BANK_OFS)
            rdata_nxt = {bank_r, 6'h00};
         else if (mode_sel)
            rdata_nxt = mode_byte;
         else if (reg_addr == pmode_pkg::MASK_OFS)
            rdata_nxt = src_to_byte(mask_r);
         else if (reg_addr == pmode_pkg::FLAG_OFS)
            rdata_nxt = src_to_byte(flags_r);
         else if (reg_addr == pmode_pkg::STAT_OFS)
            rdata_nxt = stat_byte;
         else
            rdata_nxt = 8'h00;
      end
   end

   // State registers; the reset pin and a watchdog timeout both reset fully.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bank_r      <= pmode_pkg::BANK_RST;
         prescale_r  <= pmode_pkg::PRESCALE_RST;
         sleep_sel_r <= pmode_pkg::SLEEP_SEL_RST;
         wake_edge_r <= pmode_pkg::WAKE_EDGE_RST;
         mask_r      <= byte_to_src(pmode_pkg::MASK_RST);
         flags_r     <= '0;
         gie_r       <= pmode_pkg::GIE_RST;
         warm_cnt_r  <= 16'h0000;
         mode_r      <= pmode_pkg::MODE_NORMAL;
         clk_gate_r  <= 3'b111;
         irq_req_r   <= 1'b0;
         resume_r    <= 1'b0;
         reg_rdata_r <= 8'h00;
      end
      else if (wdt_timeout)
      begin
         bank_r      <= pmode_pkg::BANK_RST;
         prescale_r  <= pmode_pkg::PRESCALE_RST;
         sleep_sel_r <= pmode_pkg::SLEEP_SEL_RST;
         wake_edge_r <= pmode_pkg::WAKE_EDGE_RST;
         mask_r      <= byte_to_src(pmode_pkg::MASK_RST);
         flags_r     <= '0;
         gie_r       <= pmode_pkg::GIE_RST;
         warm_cnt_r  <= 16'h0000;
         mode_r      <= pmode_pkg::MODE_NORMAL;
         clk_gate_r  <= 3'b111;
         irq_req_r   <= 1'b0;
         resume_r    <= 1'b0;
         reg_rdata_r <= 8'h00;
      end
      else
      begin
         bank_r      <= bank_nxt;
         prescale_r  <= prescale_nxt;
         sleep_sel_r <= sleep_sel_nxt;
         wake_edge_r <= wake_edge_nxt;
         mask_r      <= mask_nxt;
         flags_r     <= flags_nxt;
         gie_r       <= gie_nxt;
         warm_cnt_r  <= warm_cnt_nxt;
         mode_r      <= mode_nxt;
         clk_gate_r  <= clk_gate_nxt;
         irq_req_r   <= irq_req_nxt;
         resume_r    <= resume_nxt;
         reg_rdata_r <= rdata_nxt;
      end
   end

endmodule

// ===== bench/power_mode_chk.sv
`timescale 1ns/1ps
// Watches the block's outputs against its inputs.
module power_mode_chk #(
   parameter int WARMUP_CYCLES = 4
) (
   // Clock and reset.
   input wire logic                 clk,
   input wire logic                 rst_n,
   // Register port and CPU side.
   input wire logic [5:0]           reg_addr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata_r,
   input wire logic                 halt_instruction,
   input wire logic                 global_irq_on_op,
   input wire logic                 global_irq_off_op,
   input wire logic                 return_from_irq_op,
   input wire logic                 wdt_timeout,
   input wire logic                 wake_n,
   // Outputs of the block.
   input wire logic                 irq_req_r,
   input wire logic                 resume_r,
   input wire pmode_pkg::clk_gate_t clk_gate_r,
   input wire pmode_pkg::op_mode_t  mode_r
);
   int wcnt_r;
   int wcnt_nxt;
   logic gie_on;
   assign gie_on = global_irq_on_op | return_from_irq_op;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Counts consecutive warm-up cycles so the warm-up length can be checked.
   always_comb
   begin
      wcnt_nxt = (mode_r == pmode_pkg::MODE_WARMUP) ? wcnt_r + 1 : 0;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wcnt_r <= 0;
      else
         wcnt_r <= wcnt_nxt;
   end
   a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
      else $error("read data outside slot");
   a_mask_unused: assert property ($past(reg_rd) && $past(reg_addr) == pmode_pkg::MASK_OFS
      |-> reg_rdata_r[7] == 1'b0 && reg_rdata_r[1] == 1'b0) else $error("unused mask bit set");
   a_halt_enters: assert property (mode_r == pmode_pkg::MODE_NORMAL && halt_instruction
      |=> mode_r inside {pmode_pkg::MODE_IDLE, pmode_pkg::MODE_SLEEP}) else $error("halt ignored");
   a_normal_gates: assert property (mode_r == pmode_pkg::MODE_NORMAL |-> clk_gate_r == 3'b111)
      else $error("normal gates wrong");
   a_idle_gates: assert property (mode_r == pmode_pkg::MODE_IDLE |-> clk_gate_r == 3'b101)
      else $error("idle gates wrong");
   a_sleep_gates: assert property (mode_r == pmode_pkg::MODE_SLEEP |-> clk_gate_r == 3'b000)
      else $error("sleep gates wrong");
   a_gie_off: assert property (global_irq_off_op && !gie_on ##1 !gie_on |=> !irq_req_r)
      else $error("irq with global enable off");
   a_sleep_holds: assert property (mode_r == pmode_pkg::MODE_SLEEP && wake_n && $past(wake_n)
      && $past(wake_n, 2) |=> mode_r == pmode_pkg::MODE_SLEEP) else $error("sleep left without pin");
   a_warmup_len: assert property (mode_r != pmode_pkg::MODE_WARMUP && wcnt_r != 0
      |-> wcnt_r == WARMUP_CYCLES && mode_r == pmode_pkg::MODE_NORMAL) else $error("bad warm-up");
   a_resume_once: assert property (resume_r
      |-> mode_r == pmode_pkg::MODE_NORMAL && $past(mode_r) != pmode_pkg::MODE_NORMAL) else $error("bad resume");
   a_wdt_reset: assert property (wdt_timeout
      |=> mode_r == pmode_pkg::MODE_NORMAL && !irq_req_r && !resume_r) else $error("watchdog reset missed");
   c_idle: cover property (mode_r == pmode_pkg::MODE_IDLE);
   c_warm: cover property (mode_r == pmode_pkg::MODE_WARMUP);
   c_resume: cover property (resume_r);
endmodule
bind power_mode_ctrl power_mode_chk #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_chk (.clk(clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .halt_instruction(halt_instruction),
   .global_irq_on_op(global_irq_on_op), .global_irq_off_op(global_irq_off_op),
   .return_from_irq_op(return_from_irq_op), .wdt_timeout(wdt_timeout), .wake_n(wake_n),
   .irq_req_r(irq_req_r), .resume_r(resume_r), .clk_gate_r(clk_gate_r), .mode_r(mode_r));

// ===== bench/far_side_model.sv
`timescale 1ns/1ps
// Interrupt sources and the wake pin, which has a pull-up when not pressed.
module far_side_model #(
   parameter int HOLD = 8
) (
   // Clock and requests from the bench.
   input  wire logic           clk,
   input  wire logic [5:0]     fire,
   input  wire logic           press,
   // Toward the block.
   output pmode_pkg::irq_src_t irq_events,
   output logic                wake_n
);
   int cnt = 0;
   // Sources pulse for one cycle; the pin is held low for HOLD cycles.
   always @(posedge clk)
   begin
      irq_events <= fire;
      cnt <= press ? HOLD : (cnt > 0 ? cnt - 1 : 0);
   end
   assign wake_n = (cnt == 0);
endmodule

// ===== bench/tb_power_mode_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_power_mode_ctrl;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] ops = 5'h00; // Halt, on, off, return, taken.
   logic wdt_timeout = 1'b0;
   logic [5:0] fire = 6'h00;
   logic press = 1'b0;
   logic [7:0] reg_rdata_r;
   logic irq_req_r;
   logic resume_r;
   logic wake_n;
   pmode_pkg::irq_src_t irq_events;
   pmode_pkg::clk_gate_t clk_gate_r;
   pmode_pkg::op_mode_t mode_r;
   int failures = 0;
   int compares = 0;
   always #2.5 clk = ~clk;
   power_mode_ctrl #(.WARMUP_CYCLES(4)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .halt_instruction(ops[0]), .global_irq_on_op(ops[1]), .global_irq_off_op(ops[2]),
      .return_from_irq_op(ops[3]), .irq_taken(ops[4]), .irq_events(irq_events), .wdt_timeout(wdt_timeout),
      .wake_n(wake_n), .irq_req_r(irq_req_r), .resume_r(resume_r), .clk_gate_r(clk_gate_r), .mode_r(mode_r));
   far_side_model i_far (.clk(clk), .fire(fire), .press(press), .irq_events(irq_events), .wake_n(wake_n));
   // Bus, pulse and wait helpers.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_r;
   endtask
   task automatic op(input int k);
      @(posedge clk);
      ops[k] <= 1'b1;
      @(posedge clk);
      ops <= 5'h00;
      #1;
   endtask
   task automatic ev(input int k);
      @(posedge clk);
      fire[k] <= 1'b1;
      @(posedge clk);
      fire <= 6'h00;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic pin();
      @(posedge clk);
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
   endtask
   task automatic wait_resume();
      int n = 0;
      while (resume_r !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1 n++;
      end
      `CHK("resume", 1'b1, resume_r)
   endtask
   task automatic t_regs();
      logic [7:0] d;
      rd(pmode_pkg::MODE_OFS, d);
      `CHK("mode_rst", 8'h04, d)
      rd(pmode_pkg::MASK_OFS, d);
      `CHK("mask_rst", 8'h00, d)
      wr(pmode_pkg::MASK_OFS, 8'hff);
      rd(pmode_pkg::MASK_OFS, d);
      `CHK("mask_rw", 8'h7d, d)
      wr(pmode_pkg::MODE_OFS, 8'hff);
      rd(pmode_pkg::MODE_OFS, d);
      `CHK("mode_rw", 8'h77, d)
      rd(pmode_pkg::STAT_OFS, d);
      `CHK("stat_rst", 8'h01, d)
      wr(pmode_pkg::BANK_OFS, 8'h40);
      rd(pmode_pkg::BANK_OFS, d);
      `CHK("bank_rw", 8'h40, d)
      rd(pmode_pkg::MODE_OFS, d);
      `CHK("mode_bank1", 8'h00, d)
      wr(pmode_pkg::BANK_OFS, 8'h00);
      rd(6'h3f, d);
      `CHK("unmapped", 8'h00, d)
      $display("test regs done");
   endtask
   task automatic t_mask();
      logic [7:0] d;
      int mb[6] = '{0, 2, 3, 4, 5, 6};
      int j;
      for (int i = 0; i < 6; i++)
      begin
         j = (i + 1) % 6;
         wr(pmode_pkg::FLAG_OFS, 8'h00);
         wr(pmode_pkg::MASK_OFS, 8'h01 << mb[i]);
         op(i % 2 ? 3 : 1);
         ev(j);
         `CHK("irq_other", 1'b0, irq_req_r)
         ev(i);
         `CHK("irq_own", 1'b1, irq_req_r)
         op(i % 2 ? 4 : 2);
         @(posedge clk);
         #1 `CHK("irq_gie_off", 1'b0, irq_req_r)
         rd(pmode_pkg::FLAG_OFS, d);
         `CHK("flags", (8'h01 << mb[i]) | (8'h01 << mb[j]), d)
      end
      $display("test mask done");
   endtask
   task automatic t_idle();
      for (int g = 0; g < 2; g++)
      begin
         wr(pmode_pkg::MODE_OFS, 8'h00);
         wr(pmode_pkg::FLAG_OFS, 8'h00);
         wr(pmode_pkg::MASK_OFS, 8'h01);
         op(g ? 1 : 2);
         op(0);
         `CHK("idle_mode", pmode_pkg::MODE_IDLE, mode_r)
         `CHK("idle_gate", 3'b101, clk_gate_r)
         pin();
         ev(1);
         `CHK("idle_stays", pmode_pkg::MODE_IDLE, mode_r)
         ev(0);
         `CHK("idle_exit", pmode_pkg::MODE_NORMAL, mode_r)
         `CHK("idle_irq", g[0], irq_req_r)
      end
      $display("test idle done");
   endtask
   task automatic t_sleep();
      logic [7:0] d;
      for (int e = 0; e < 2; e++)
      begin
         wr(pmode_pkg::FLAG_OFS, 8'h00);
         wr(pmode_pkg::MODE_OFS, {7'h01, e[0]});
         wr(pmode_pkg::MASK_OFS, 8'h7d);
         if (e == 0)
            pin();
         op(0);
         if (e == 1)
         begin
            `CHK("sleep_mode", pmode_pkg::MODE_SLEEP, mode_r)
            `CHK("sleep_gate", 3'b000, clk_gate_r)
            ev(0);
            `CHK("sleep_stays", pmode_pkg::MODE_SLEEP, mode_r)
            pin();
         end
         wait_resume();
         `CHK("wake_mode", pmode_pkg::MODE_NORMAL, mode_r)
         rd(pmode_pkg::FLAG_OFS, d);
         `CHK("sleep_flag", {7'h00, e[0]}, d)
      end
      $display("test sleep done");
   endtask
   task automatic t_reset();
      logic [7:0] d;
      wr(pmode_pkg::MODE_OFS, 8'h03);
      op(0);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 `CHK("reset_mode", pmode_pkg::MODE_NORMAL, mode_r)
      @(posedge clk);
      rst_n <= 1'b1;
      rd(pmode_pkg::MODE_OFS, d);
      `CHK("reset_reg", 8'h04, d)
      op(0);
      @(posedge clk);
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      #1 `CHK("wdt_mode", pmode_pkg::MODE_NORMAL, mode_r)
      $display("test reset done");
   endtask
   // Ends the run with the verdict.
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_mask();
      t_idle();
      t_sleep();
      t_reset();
      test_done();
   end
   // Cuts a hang short.
   initial
   begin
      #20000;
      failures++;
      test_done();
   end
endmodule
